//--- logic/smartcard_regs_pkg.sv
/*
 * Register map, field positions and reset values of the global
 * interrupt, GPIO and settings block. Assumes nothing of its users.
 */
package smartcard_regs_pkg;
    localparam int         GPIO_COUNT      = 4;
    localparam logic [7:0] ADDR_VERSION    = 8'h40;
    localparam logic [7:0] ADDR_STATUS     = 8'h41;
    localparam logic [7:0] ADDR_SETTINGS   = 8'h42;
    localparam logic [7:0] ADDR_GPIO       = 8'h43;
    localparam logic [7:0] ADDR_MASK       = 8'h44;
    // Status bit positions
    localparam int         ST_USER         = 7;
    localparam int         ST_MODULE_LSB   = 4;
    localparam int         ST_THERMAL      = 3;
    localparam int         ST_SUPERVISOR   = 2;
    localparam int         ST_SYNC         = 1;
    localparam int         ST_GPIO         = 0;
    // Mask bit positions
    localparam int         MK_SOON         = 7;
    localparam int         MK_TIMEOUT      = 6;
    localparam int         MK_OVERCURRENT  = 5;
    localparam int         MK_SYNC         = 4;
    localparam int         MK_THERMAL      = 3;
    localparam int         MK_SUPERVISOR   = 2;
    localparam int         MK_GPIO         = 1;
    localparam int         MK_PRESENCE     = 0;
    // Settings and GPIO fields
    localparam int         SET_BOOST       = 7;
    localparam int         SET_DIR_LSB     = 2;
    localparam int         LVL_IN_LSB      = 4;
    // Reset values
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic       BOOST_RESET     = 1'b1;
    localparam logic [3:0] DIR_RESET       = 4'h0;
    localparam logic [3:0] DRIVE_RESET     = 4'hf;
    localparam logic [7:0] MASK_RESET      = 8'h00;
    localparam logic [7:0] VERSION_DEFAULT = 8'h5a; // Arbitrary code
endpackage : smartcard_regs_pkg

//--- logic/block_link_if.sv
/*
 * Carrier between the register core and its GPIO and status helpers.
 * Assumes all parties run on the same clock.
 */
`timescale 1ns/1ns
interface block_link_if;
    logic [3:0] dir;
    logic [3:0] drive;
    logic [3:0] level;
    logic       changed;
    logic [7:0] setEvents;
    logic       readClear;
    logic [7:0] status;
    modport regs (output dir, drive, setEvents, readClear, input level, changed, status);
    modport gpio (input dir, drive, output level, changed);
    modport irq  (input setEvents, readClear, output status);
endinterface : block_link_if

//--- logic/gpio_port.sv
/*
 * Four GPIO pins: input synchroniser, change detect, direction and
 * output drive. Assumes pin levels are asynchronous to clk.
 */
`timescale 1ns/1ns
module gpio_port
    import smartcard_regs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    input  wire logic [3:0]        pinIn,
    output logic      [3:0]        pinOut,
    output logic      [3:0]        pinOe,
    block_link_if.gpio             link
);
    logic [3:0] meta, sync, prev, out, oe;
    logic [3:0] next_meta, next_sync, next_prev, next_out, next_oe;

    always_comb begin
        next_meta = meta;
        next_sync = sync;
        next_prev = prev;
        next_out  = out;
        next_oe   = oe;
        if (ce) begin
            next_meta = pinIn;
            next_sync = meta;
            next_prev = sync;
            next_oe   = ~link.dir;
            next_out  = link.drive;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= 4'h0;
            sync <= 4'h0;
            prev <= 4'h0;
            out  <= DRIVE_RESET;
            oe   <= ~DIR_RESET;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
            out  <= next_out;
            oe   <= next_oe;
        end
    end

    assign link.level   = sync;
    assign link.changed = ce && |((sync ^ prev) & link.dir);
    assign pinOut       = out;
    assign pinOe        = oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_pin_direction: assert property (ce |=> pinOe == ~$past(link.dir))
        else $error("pin enable does not follow direction");
    chk_drive_level: assert property (ce |=> pinOut == $past(link.drive))
        else $error("pin level does not follow drive bits");
endmodule : gpio_port

//--- logic/irq_status.sv
/*
 * Sticky interrupt status flags, cleared by a status read.
 * Assumes set and clear strobes arrive on clk, one cycle each.
 */
`timescale 1ns/1ns
module irq_status
    import smartcard_regs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    block_link_if.irq              link
);
    logic [7:0] flags, next_flags;

    always_comb begin
        next_flags = flags;
        // A set in the clearing cycle survives
        if (ce)
            next_flags = (flags & ~{8{link.readClear}}) | link.setEvents;
    end

    always_ff @(posedge clk) begin
        if (reset)
            flags <= STATUS_RESET;
        else
            flags <= next_flags;
    end

    assign link.status = flags;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_set_wins: assert property (ce && link.readClear |=> flags == $past(link.setEvents))
        else $error("read clear lost a new event");
endmodule : irq_status

//--- logic/smartcard_irq_gpio_regs.sv
/*
 * Global register block: version, interrupt status, device settings,
 * GPIO levels and user card interrupt mask, with interrupt pin.
 * Assumes the register port and event pulses come from logic on clk
 * and that GPIO pin levels are asynchronous.
 */
`timescale 1ns/1ns
// Functional notes
// - User card events set status bit 7
// - Module events set status bits 6..4
// - Interrupt pin low while any flag set
// - Status flags read-only, cleared by reading
// - Thermal deactivation sets status bit 3
// - Supervisor deactivation sets status bit 2
// - Sync activation complete sets status bit 1
// - GPIO input change sets status bit 0
// - Settings bit 7 boost enable, reset 1
// - Settings bits 5..2 GPIO direction, reset 0
// - GPIO bits 7..4 read pin levels
// - GPIO bits 3..0 drive levels, reset 1
// - Mask bits 7..5 block early/timeout/overcurrent
// - Mask bit 4 blocks sync complete
// - Mask bit 3 blocks thermal shutdown
// - Mask bit 2 blocks supervisor fault
// - Mask bit 1 blocks all GPIO inputs
// - Mask bit 0 blocks presence change
// - Mask bit one masks, zero unmasks
module smartcard_irq_gpio_regs
    import smartcard_regs_pkg::*;
#(
    parameter logic [7:0] VERSION_CODE = VERSION_DEFAULT
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    input  wire logic [7:0]        regAddr,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire logic [7:0]        regWdata,
    output logic      [7:0]        regRdata,
    output logic                   regRvalid,
    input  wire logic              userOvercurrent,
    input  wire logic              userAnswerTimeout,
    input  wire logic              userAnswerSoon,
    input  wire logic              userSupplyRamp,
    input  wire logic              userPresenceChange,
    input  wire logic [3:1]        moduleEvent,
    input  wire logic              thermalDeact,
    input  wire logic              supervisorDeact,
    input  wire logic              syncComplete,
    input  wire logic [3:0]        gpioIn,
    output logic      [3:0]        gpioOut,
    output logic      [3:0]        gpioOe,
    output logic                   boostEnable,
    output logic                   irqPinN
);
    block_link_if link ();

    logic       boost, next_boost;
    logic [3:0] dir, next_dir;
    logic [3:0] drive, next_drive;
    logic [7:0] mask, next_mask;
    logic [7:0] rdata, next_rdata;
    logic       rvalid, next_rvalid;
    logic       pinN, next_pinN;
    logic [7:0] events;
    logic       userHit;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    function automatic logic pass(input logic ev, input logic block);
        pass = ev & ~block;
    endfunction : pass

    gpio_port u_gpio (
        .clk    (clk),
        .reset  (reset),
        .ce     (ce),
        .pinIn  (gpioIn),
        .pinOut (gpioOut),
        .pinOe  (gpioOe),
        .link   (link.gpio)
    );

    irq_status u_irq (
        .clk    (clk),
        .reset  (reset),
        .ce     (ce),
        .link   (link.irq)
    );

    // Event gathering, masked events never reach the flags
    always_comb begin
        userHit = pass(userAnswerSoon, mask[MK_SOON])
                | pass(userAnswerTimeout, mask[MK_TIMEOUT])
                | pass(userOvercurrent, mask[MK_OVERCURRENT])
                | pass(userPresenceChange, mask[MK_PRESENCE])
                | userSupplyRamp;
        events = 8'h00;
        events[ST_USER] = userHit;
        events[ST_MODULE_LSB +: 3] = {moduleEvent[1], moduleEvent[2], moduleEvent[3]};
        events[ST_THERMAL] = pass(thermalDeact, mask[MK_THERMAL]);
        events[ST_SUPERVISOR] = pass(supervisorDeact, mask[MK_SUPERVISOR]);
        events[ST_SYNC] = pass(syncComplete, mask[MK_SYNC]);
        events[ST_GPIO] = pass(link.changed, mask[MK_GPIO]);
        if (!ce)
            events = 8'h00;
    end

    assign link.setEvents = events;
    assign link.readClear = ce && regRead && hit(regAddr, ADDR_STATUS);
    assign link.dir       = dir;
    assign link.drive     = drive;

    // Register writes
    always_comb begin
        next_boost = boost;
        next_dir   = dir;
        next_drive = drive;
        next_mask  = mask;
        if (ce && regWrite) begin
            if (hit(regAddr, ADDR_SETTINGS)) begin
                next_boost = regWdata[SET_BOOST];
                next_dir   = regWdata[SET_DIR_LSB +: GPIO_COUNT];
            end
            if (hit(regAddr, ADDR_GPIO))
                next_drive = regWdata[GPIO_COUNT-1:0];
            if (hit(regAddr, ADDR_MASK))
                next_mask = regWdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            boost <= BOOST_RESET;
            dir   <= DIR_RESET;
            drive <= DRIVE_RESET;
            mask  <= MASK_RESET;
        end else begin
            boost <= next_boost;
            dir   <= next_dir;
            drive <= next_drive;
            mask  <= next_mask;
        end
    end

    // Read data, answer one cycle after the strobe
    always_comb begin
        next_rdata  = rdata;
        next_rvalid = rvalid;
        next_pinN   = pinN;
        if (ce) begin
            next_rvalid = regRead;
            next_pinN   = ~|link.status;
            if (regRead) begin
                unique case (regAddr)
                    ADDR_VERSION:  next_rdata = VERSION_CODE;
                    ADDR_STATUS:   next_rdata = link.status;
                    ADDR_SETTINGS: next_rdata = {boost, 1'b0, dir, 2'b00};
                    ADDR_GPIO:     next_rdata = {link.level, drive};
                    ADDR_MASK:     next_rdata = mask;
                    default:       next_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
            pinN   <= 1'b1;
        end else begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
            pinN   <= next_pinN;
        end
    end

    assign regRdata    = rdata;
    assign regRvalid   = rvalid;
    assign irqPinN     = pinN;
    assign boostEnable = boost;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_user_summary: assert property (
        ce && userAnswerSoon && !mask[MK_SOON] |=> link.status[ST_USER])
        else $error("user event did not set summary flag");
    chk_supply_ramp: assert property (
        ce && userSupplyRamp ##1 ce && regRead && hit(regAddr, ADDR_STATUS)
        |=> regRdata[ST_USER])
        else $error("supply ramp not reported");
    chk_module_summary: assert property (
        ce && moduleEvent[1] |=> link.status[6])
        else $error("module one event did not set bit 6");
    chk_module_three: assert property (
        ce && moduleEvent[3] |=> link.status[ST_MODULE_LSB])
        else $error("module three event did not set bit 4");
    chk_irq_pin: assert property (
        ce && |link.status |=> !irqPinN)
        else $error("pin high while a flag is set");
    chk_pin_release: assert property (
        ce && link.status == 8'h00 |=> irqPinN)
        else $error("pin low with no flag set");
    chk_read_clears: assert property (
        link.readClear && link.setEvents == 8'h00 |=> link.status == 8'h00)
        else $error("status not cleared by read");
    chk_read_value: assert property (
        link.readClear |=> regRvalid && regRdata == $past(link.status))
        else $error("status read returned wrong value");
    chk_thermal_flag: assert property (
        ce && thermalDeact && !mask[MK_THERMAL] |=> link.status[ST_THERMAL])
        else $error("thermal event lost");
    chk_supervisor_flag: assert property (
        ce && supervisorDeact && !mask[MK_SUPERVISOR] |=> link.status[ST_SUPERVISOR])
        else $error("supervisor event lost");
    chk_sync_flag: assert property (
        ce && syncComplete && !mask[MK_SYNC] |=> link.status[ST_SYNC])
        else $error("sync complete event lost");
    chk_gpio_flag: assert property (
        link.changed && !mask[MK_GPIO] |=> link.status[ST_GPIO])
        else $error("gpio change lost");
    chk_boost_write: assert property (
        ce && regWrite && hit(regAddr, ADDR_SETTINGS) |=> boostEnable == $past(regWdata[SET_BOOST]))
        else $error("boost bit not written");
    chk_gpio_readback: assert property (
        ce && regRead && hit(regAddr, ADDR_GPIO) |=> regRdata[7:4] == $past(link.level))
        else $error("gpio levels not returned");
    chk_masked_quiet: assert property (
        ce && thermalDeact && mask[MK_THERMAL] && !link.status[ST_THERMAL]
        && !link.readClear |=> !link.status[ST_THERMAL])
        else $error("masked thermal event set flag");
    chk_masked_block: assert property (
        link.changed && mask[MK_GPIO] && !link.status[ST_GPIO] |=> !link.status[ST_GPIO])
        else $error("masked gpio change set flag");
    chk_version_read: assert property (
        ce && regRead && hit(regAddr, ADDR_VERSION) |=> regRdata == VERSION_CODE)
        else $error("version read wrong");

    // Masked events never reach the flags
    chk_soon_masked: assert property (
        ce && userAnswerSoon && mask[MK_SOON] && !userAnswerTimeout && !userOvercurrent
        && !userSupplyRamp && !userPresenceChange |-> !events[ST_USER])
        else $error("masked early answer reached summary");
    chk_timeout_masked: assert property (
        ce && userAnswerTimeout && mask[MK_TIMEOUT] && !userAnswerSoon && !userOvercurrent
        && !userSupplyRamp && !userPresenceChange |-> !events[ST_USER])
        else $error("masked answer timeout reached summary");
    chk_over_masked: assert property (
        ce && userOvercurrent && mask[MK_OVERCURRENT] && !userAnswerSoon && !userAnswerTimeout
        && !userSupplyRamp && !userPresenceChange |-> !events[ST_USER])
        else $error("masked overcurrent reached summary");
    chk_presence_masked: assert property (
        ce && userPresenceChange && mask[MK_PRESENCE] && !userAnswerSoon && !userAnswerTimeout
        && !userOvercurrent && !userSupplyRamp |-> !events[ST_USER])
        else $error("masked presence change reached summary");
    chk_sync_masked: assert property (
        ce && syncComplete && mask[MK_SYNC] |-> !events[ST_SYNC])
        else $error("masked sync complete reached flag");
    chk_thermal_masked: assert property (
        ce && thermalDeact && mask[MK_THERMAL] |-> !events[ST_THERMAL])
        else $error("masked thermal event reached flag");
    chk_super_masked: assert property (
        ce && supervisorDeact && mask[MK_SUPERVISOR] |-> !events[ST_SUPERVISOR])
        else $error("masked supervisor event reached flag");
    chk_gpio_masked: assert property (
        link.changed && mask[MK_GPIO] |-> !events[ST_GPIO])
        else $error("masked gpio change reached flag");

    // Unmasked events set their flags; flags hold until a status read, pin stays high when nothing is pending
    chk_presence_flag: assert property (
        ce && userPresenceChange && !mask[MK_PRESENCE] |=> link.status[ST_USER])
        else $error("presence change lost");
    chk_timeout_flag: assert property (
        ce && userAnswerTimeout && !mask[MK_TIMEOUT] |=> link.status[ST_USER])
        else $error("answer timeout lost");
    chk_over_flag: assert property (
        ce && userOvercurrent && !mask[MK_OVERCURRENT] |=> link.status[ST_USER])
        else $error("overcurrent lost");
    chk_ramp_flag: assert property (
        ce && userSupplyRamp |=> link.status[ST_USER])
        else $error("supply ramp lost");
    chk_module_two: assert property (
        ce && moduleEvent[2] |=> link.status[5])
        else $error("module two event did not set bit 5");
    chk_flags_sticky: assert property (
        ce && !link.readClear
        |=> (link.status & $past(link.status)) == $past(link.status))
        else $error("flag cleared without a status read");
    chk_pin_quiet: assert property (
        ce && link.status == 8'h00 && link.setEvents == 8'h00 |=> ##1 irqPinN)
        else $error("pin low with nothing pending");

    // Register writes and read-back
    chk_dir_write: assert property (
        ce && regWrite && hit(regAddr, ADDR_SETTINGS)
        |=> dir == $past(regWdata[SET_DIR_LSB +: GPIO_COUNT]))
        else $error("direction bits not written");
    chk_drive_write: assert property (
        ce && regWrite && hit(regAddr, ADDR_GPIO) |=> drive == $past(regWdata[GPIO_COUNT-1:0]))
        else $error("drive bits not written");
    chk_mask_write: assert property (
        ce && regWrite && hit(regAddr, ADDR_MASK) |=> mask == $past(regWdata))
        else $error("mask not written");
    chk_version_write: assert property (
        ce && regWrite && hit(regAddr, ADDR_VERSION)
        |=> $stable(boost) && $stable(dir) && $stable(drive) && $stable(mask))
        else $error("version write changed a register");
    chk_status_write: assert property (
        ce && regWrite && !regRead && hit(regAddr, ADDR_STATUS) && link.setEvents == 8'h00
        |=> link.status == $past(link.status))
        else $error("status write changed the flags");
    chk_settings_read: assert property (
        ce && regRead && hit(regAddr, ADDR_SETTINGS)
        |=> regRdata[SET_BOOST] == $past(boostEnable) && regRdata[6] == 1'b0 && regRdata[1:0] == 2'b00)
        else $error("settings read wrong");
    chk_dir_read: assert property (
        ce && regRead && hit(regAddr, ADDR_SETTINGS) |=> regRdata[SET_DIR_LSB +: GPIO_COUNT] == $past(dir))
        else $error("direction read wrong");
    chk_drive_read: assert property (
        ce && regRead && hit(regAddr, ADDR_GPIO) |=> regRdata[GPIO_COUNT-1:0] == $past(drive))
        else $error("drive read wrong");
    chk_mask_read: assert property (
        ce && regRead && hit(regAddr, ADDR_MASK) |=> regRdata == $past(mask))
        else $error("mask read wrong");
    chk_read_answer: assert property (
        ce && regRead |=> regRvalid)
        else $error("read not answered");
    chk_answer_once: assert property (
        ce && !regRead |=> !regRvalid)
        else $error("answer without a read");

    cov_status_read: cover property (link.readClear && |link.status);
    cov_gpio_change: cover property (link.changed ##1 !irqPinN);
    cov_masked_event: cover property (ce && userOvercurrent && mask[MK_OVERCURRENT]);
    cov_set_on_clear: cover property (link.readClear && |link.setEvents);
    cov_masked_quiet: cover property (ce && thermalDeact && mask[MK_THERMAL] ##2 irqPinN);
endmodule : smartcard_irq_gpio_regs

//--- dv/host_model.sv
/*
 * Host side model: master of the register port and the world outside
 * the four GPIO pins. Assumes the block samples its port on rising clk.
 */
`timescale 1ns/1ns
module host_model (
    input  wire logic       clk,
    input  wire logic [3:0] gpioOut,
    input  wire logic [3:0] gpioOe,
    input  wire logic [3:0] extLevel,
    output logic      [3:0] gpioIn,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWdata
);
    // Pin level: block drives when enabled, outside source otherwise
    assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & extLevel);

    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
    end

    task access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        regAddr = addr;
        regWdata = data;
        regWrite = wr;
        regRead = !wr;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regRead = 1'b0;
        // Released bus shows no stale value
        regAddr = ~addr;
        regWdata = ~data;
    endtask : access
endmodule : host_model

//--- dv/smartcard_irq_gpio_regs_tb_top.sv
/*
 * Self-checking bench of the global register block: reset values,
 * events, masks, read-clear and GPIO. Assumes host_model is compiled.
 */
`timescale 1ns/1ns
module smartcard_irq_gpio_regs_tb_top;
    import smartcard_regs_pkg::*;
    localparam logic [7:0] VERSION_TB = 8'h3c; // Arbitrary version code
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic [10:0] ev;
    logic [3:0]  extLevel;
    logic [3:0]  gpioIn;
    logic [3:0]  gpioOut;
    logic [3:0]  gpioOe;
    logic [7:0]  regAddr;
    logic [7:0]  regWdata;
    logic [7:0]  regRdata;
    logic        regWrite;
    logic        regRead;
    logic        regRvalid;
    logic        boostEnable;
    logic        irqPinN;
    logic [7:0]  expQ[$];
    logic [7:0]  mask;
    logic [7:0]  pend;
    logic [31:0] seed = 32'hf175a898;
    int          errors = 0;
    int          samplesChecked = 0;
    // Status bit and mask bit of each event; mask 8 means no mask
    int          evBit[11] = '{7, 7, 7, 7, 7, 6, 5, 4, 3, 2, 1};
    int          evMask[11] = '{5, 6, 7, 8, 0, 8, 8, 8, 3, 2, 4};

    always #20 clk = ~clk;

    smartcard_irq_gpio_regs #(.VERSION_CODE(VERSION_TB)) uut (
        .clk(clk), .reset(reset), .ce(ce), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
        .userOvercurrent(ev[0]), .userAnswerTimeout(ev[1]), .userAnswerSoon(ev[2]),
        .userSupplyRamp(ev[3]), .userPresenceChange(ev[4]), .moduleEvent(ev[7:5]),
        .thermalDeact(ev[8]), .supervisorDeact(ev[9]), .syncComplete(ev[10]),
        .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .boostEnable(boostEnable),
        .irqPinN(irqPinN));

    host_model host (
        .clk(clk), .gpioOut(gpioOut), .gpioOe(gpioOe), .extLevel(extLevel), .gpioIn(gpioIn),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rd

    task waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitc

    task pulse(input int k);
        @(posedge clk);
        #1;
        ev[k] = 1'b1;
        @(posedge clk);
        #1;
        ev = '0;
    endtask : pulse

    // Read data compared against the oldest note
    always @(posedge clk) begin
        if (regRvalid === 1'b1) begin
            if (expQ.size() == 0) begin
                check(regRdata, 8'hxx);
            end else begin
                check(regRdata, expQ.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        wrap_up;
    end

    initial begin
        ev = '0;
        extLevel = 4'hf;
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        check({7'h00, boostEnable}, {7'h00, BOOST_RESET});
        check({4'h0, gpioOe}, 8'h0f);
        check({4'h0, gpioOut}, {4'h0, DRIVE_RESET});
        check({7'h00, irqPinN}, 8'h01);
        rd(ADDR_VERSION, VERSION_TB);
        rd(ADDR_STATUS, 8'h00);
        rd(ADDR_SETTINGS, 8'h80);
        rd(ADDR_GPIO, 8'hff);
        rd(ADDR_MASK, 8'h00);
        rd(8'h47, 8'h00);
        wr(ADDR_VERSION, 8'hff);
        wr(ADDR_STATUS, 8'hff);
        rd(ADDR_VERSION, VERSION_TB);
        rd(ADDR_STATUS, 8'h00);
        $display("test reset values done");
        // Every event unmasked first, then under random masks
        for (int n = 0; n < 33; n++) begin
            mask = (n < 11) ? 8'h00 : seed[7:0];
            seed = xs(seed);
            wr(ADDR_MASK, mask);
            pulse(n % 11);
            pend = (evMask[n % 11] < 8 && mask[evMask[n % 11]]) ? 8'h00 : 8'h01 << evBit[n % 11];
            waitc(2);
            check({7'h00, irqPinN}, {7'h00, pend == 8'h00});
            rd(ADDR_MASK, mask);
            rd(ADDR_STATUS, pend);
            waitc(2);
            check({7'h00, irqPinN}, 8'h01);
            rd(ADDR_STATUS, 8'h00);
        end
        $display("test events and masks done");
        wr(ADDR_MASK, 8'h00);
        // Event while frozen must be ignored
        ce = 1'b0;
        pulse(8);
        ce = 1'b1;
        waitc(2);
        check({7'h00, irqPinN}, 8'h01);
        rd(ADDR_STATUS, 8'h00);
        $display("test clock enable done");
        wr(ADDR_SETTINGS, 8'h14);
        wr(ADDR_GPIO, 8'hf0);
        waitc(2);
        check({7'h00, boostEnable}, 8'h00);
        check({4'h0, gpioOe}, 8'h0a);
        check({4'h0, gpioOut}, 8'h00);
        rd(ADDR_SETTINGS, 8'h14);
        rd(ADDR_GPIO, 8'h50);
        rd(ADDR_STATUS, 8'h00);
        extLevel = 4'b1110;
        waitc(6);
        check({7'h00, irqPinN}, 8'h00);
        rd(ADDR_STATUS, 8'h01);
        wr(ADDR_MASK, 8'h02);
        extLevel = 4'b1010;
        waitc(6);
        check({7'h00, irqPinN}, 8'h01);
        rd(ADDR_STATUS, 8'h00);
        $display("test gpio done");
        for (int i = 0; i < 50 && expQ.size() > 0; i++) begin
            @(posedge clk);
        end
        if (expQ.size() > 0) begin
            errors++;
            $display("CHECK FAILED at %0t: reads left unanswered", $time);
        end
        wrap_up;
    end
endmodule : smartcard_irq_gpio_regs_tb_top
